// File: mmb_pkg.sv
// Shared constants, carriers and the machine-cycle divider of the memory bus.
// Assumes a single 100 MHz clock and synchronous, active-high reset.
//
// Functional notes
// - Address latch strobe pulses per external access; low byte latched on fall.
// - Fetch strobe low enables program memory; memory drives only then.
// - Low port carries address byte then data byte, time-multiplexed.
// - High port carries the high address byte during external access.
// - Data reads strobe bit 7, data writes strobe bit 6 of strobe port.
// - Interrupt vectors sit 8 bytes apart from 0003H up to 0023H.
// - Program space spans 64K, 0000H to FFFFH.
// - Strap low during reset sends every fetch to external memory.
// - Strap high during reset fetches 0000H-0FFFH from internal ROM.
// - Fetches above 0FFFH always go external, whatever the strap.
// - External data reached only by data moves, with 16-bit pointer address.
// - Register-indexed data moves give only an 8-bit address.
// - Internal data addresses are always one byte wide.
// - 192 bytes of internal RAM at 00H-BFH; 80H-BFH reachable only indirectly.
// - Upper 128 addresses decode to special registers only when direct.
// - Indirect accesses to 80H-BFH go to internal RAM; C0H-FFH has none.

// ****************************************************************
// Package
// ****************************************************************
package mmb_pkg;
   localparam logic [15:0] ROM_TOP       = 16'h0FFF;
   localparam logic [15:0] PROG_TOP      = 16'hFFFF;
   localparam logic [15:0] VEC_BASE      = 16'h0003;
   localparam logic [15:0] VEC_STEP      = 16'h0008;
   localparam logic [15:0] VEC_LAST      = 16'h0023;
   localparam logic [2:0]  VEC_NUM       = 3'h5;
   localparam int unsigned IRAM_BYTES    = 192;
   localparam logic [7:0]  IRAM_TOP      = 8'hBF;
   localparam logic [7:0]  SFR_BASE      = 8'h80;
   localparam int unsigned RD_BIT        = 7;
   localparam int unsigned WR_BIT        = 6;
   localparam logic [7:0]  STROBE_IDLE   = 8'hFF;
   localparam logic [7:0]  IDX_HIGH      = 8'h00;
   localparam logic [7:0]  UNMAPPED_DATA = 8'h00;
   localparam int unsigned RST_MC        = 2;
   localparam int unsigned MC_DIV        = 12;

   typedef enum logic [1:0] {
      KIND_FETCH  = 2'h0,
      KIND_VECTOR = 2'h1,
      KIND_XREAD  = 2'h2,
      KIND_XWRITE = 2'h3
   } mmb_kind_type;

   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_ADDR  = 5'h02,
      ST_LATCH = 5'h04,
      ST_DATA  = 5'h08,
      ST_ROM   = 5'h10
   } mmb_state_type;

   typedef struct packed {
      logic         valid;
      mmb_kind_type kind;
      logic         idx_mode;
      logic [15:0]  addr;
      logic [7:0]   wdata;
   } mmb_req_type;

   typedef struct packed {
      logic       done;
      logic [7:0] rdata;
      logic       internal;
   } mmb_ack_type;

   typedef struct packed {
      logic       valid;
      logic       write;
      logic       indirect;
      logic [7:0] addr;
      logic [7:0] wdata;
   } mmb_imem_req_type;

   typedef struct packed {
      logic       done;
      logic [7:0] rdata;
   } mmb_imem_ack_type;

   typedef struct packed {
      logic       sel;
      logic       write;
      logic [7:0] addr;
      logic [7:0] wdata;
   } mmb_sfr_req_type;

   typedef struct packed {
      logic       ale;
      logic       psen_n;
      logic [7:0] strobe;
      logic [7:0] ad_out;
      logic       ad_oe;
      logic [7:0] hi;
   } mmb_ext_type;

   // Vector address of an interrupt source; out-of-range sources clamp to the last
   function automatic logic [15:0] mmb_vector_addr(input logic [2:0] src);
      logic [15:0] a;
      a = VEC_LAST;
      if (src < VEC_NUM) begin
         a = VEC_BASE + VEC_STEP * {13'h0000, src};
      end
      return a;
   endfunction : mmb_vector_addr
endpackage : mmb_pkg

// ****************************************************************
// Machine-cycle divider
// ****************************************************************
module mmb_tick_div #(
   parameter int unsigned DIV = mmb_pkg::MC_DIV
) (
   input  wire logic i_clk,
   input  wire logic i_srst,
   output logic      o_tick
);
   import mmb_pkg::*;
   localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          tick;
   } mmb_div_type;

   mmb_div_type s_q;
   mmb_div_type s_d;

   // Free-running through the reset pin, since the oscillator keeps going; only block reset clears it
   always_comb begin
      s_d      = s_q;
      s_d.tick = 1'b0;
      if (s_q.cnt == CW'(DIV - 1)) begin
         s_d.cnt  = '0;
         s_d.tick = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + CW'(1);
      end
      if (i_srst) begin
         s_d = '0;
      end
   end

   always_ff @(posedge i_clk) begin
      s_q <= s_d;
   end

   assign o_tick = s_q.tick;
endmodule : mmb_tick_div

// File: mmb_bus.sv
// Memory map decode and multiplexed external bus engine.
// Assumes the core holds a request until busy rises, and that external
// program and data memory drive the low port only while a strobe is low.

// ****************************************************************
// Top module
// ****************************************************************
module mmb_bus #(
   parameter int unsigned MC_DIV_P = mmb_pkg::MC_DIV,
   parameter int unsigned RST_MC_P = mmb_pkg::RST_MC
) (
   input  wire logic                      i_clk,
   input  wire logic                      i_srst,
   input  wire logic                      i_reset_pin,
   input  wire logic                      i_fetch_source_strap,
   input  wire mmb_pkg::mmb_req_type      i_req,
   output mmb_pkg::mmb_ack_type           o_ack,
   output logic                           o_busy,
   output logic [15:0]                    o_rom_addr,
   input  wire logic [7:0]                i_rom_data,
   input  wire mmb_pkg::mmb_imem_req_type i_imem,
   output mmb_pkg::mmb_imem_ack_type      o_imem_ack,
   output mmb_pkg::mmb_sfr_req_type       o_sfr,
   input  wire logic [7:0]                i_sfr_rdata,
   output logic                           o_ale,
   output logic                           o_psen_n,
   output logic [7:0]                     o_strobe_port,
   output logic [7:0]                     o_low_addr_data_port,
   output logic                           o_low_addr_data_port_oe,
   input  wire logic [7:0]                i_low_addr_data_port,
   output logic [7:0]                     o_high_addr_port,
   output logic                           o_core_reset,
   output logic                           o_fetch_internal
);
   import mmb_pkg::*;

   localparam logic [7:0] RST_CNT = 8'(RST_MC_P);

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      mmb_state_type                st;
      logic [7:0]                   rst_cnt;
      logic                         core_rst;
      logic                         strap;
      mmb_kind_type                 kind;
      logic [7:0]                   wdata;
      mmb_ext_type                  ext;
      logic [15:0]                  rom_addr;
      mmb_ack_type                  ack;
      logic                         busy;
      logic                         imem_pend;
      mmb_imem_ack_type             imem_ack;
      mmb_sfr_req_type              sfr;
      logic [IRAM_BYTES-1:0][7:0]   ram;
   } mmb_core_type;

   mmb_core_type s_q;
   mmb_core_type s_d;
   logic         tick;

   // Machine-cycle enable shared by reset filter and bus phases
   mmb_tick_div #(
      .DIV (MC_DIV_P)
   ) u_div (
      .i_clk  (i_clk),
      .i_srst (i_srst),
      .o_tick (tick)
   );

   // ****************************************************************
   // Next-state logic
   // ****************************************************************
   always_comb begin
      logic [15:0] addr_eff;
      logic        is_fetch;
      logic [7:0]  ia;
      addr_eff = 16'h0000;
      is_fetch = 1'b0;
      ia       = 8'h00;

      s_d               = s_q;
      s_d.ack.done      = 1'b0;    // One-cycle completion pulses
      s_d.imem_ack.done = 1'b0;
      s_d.sfr.sel       = 1'b0;

      // two-cycle reset filter
      // A glitch shorter than one machine cycle never resets the core
      if (i_reset_pin) begin
         if (tick && (s_q.rst_cnt < RST_CNT)) begin
            s_d.rst_cnt = s_q.rst_cnt + 8'h01;
         end
         if (tick && ((s_q.rst_cnt + 8'h01) >= RST_CNT)) begin
            s_d.core_rst = 1'b1;
         end
      end else begin
         s_d.rst_cnt  = 8'h00;
         s_d.core_rst = 1'b0;
      end

      // strap tracked during reset
      // The value held at release stays in force until the next reset
      if (s_q.core_rst) begin
         s_d.strap = i_fetch_source_strap;
      end

      // ****************************************************************
      // External bus sequencer
      // ****************************************************************
      case (s_q.st)
         ST_IDLE: begin
            // Requests start on a machine-cycle boundary so every phase is full length
            if (tick && i_req.valid && !s_q.core_rst) begin
               is_fetch = (i_req.kind == KIND_FETCH) || (i_req.kind == KIND_VECTOR);
               if (i_req.kind == KIND_VECTOR) begin
                  addr_eff = mmb_vector_addr(i_req.addr[2:0]);
               end else begin
                  addr_eff = i_req.addr & PROG_TOP;
               end
               s_d.kind  = i_req.kind;
               s_d.wdata = i_req.wdata;
               s_d.busy  = 1'b1;
               if (is_fetch && s_q.strap && (addr_eff <= ROM_TOP)) begin
                  s_d.rom_addr = addr_eff;
                  s_d.st       = ST_ROM;
               end else begin
                  s_d.ext.ale    = 1'b1;
                  s_d.ext.ad_out = addr_eff[7:0];
                  s_d.ext.ad_oe  = 1'b1;
                  s_d.ext.hi     = addr_eff[15:8];
                  if (!is_fetch && i_req.idx_mode) begin
                     s_d.ext.hi = IDX_HIGH;
                  end
                  s_d.st = ST_ADDR;
               end
            end
         end
         ST_ADDR: begin
            // falling latch edge
            // Address stays on the low port across the fall for hold time
            if (tick) begin
               s_d.ext.ale = 1'b0;
               s_d.st      = ST_LATCH;
            end
         end
         ST_LATCH: begin
            if (tick) begin
               if (s_q.kind == KIND_XWRITE) begin
                  s_d.ext.ad_out         = s_q.wdata;
                  s_d.ext.ad_oe          = 1'b1;
                  s_d.ext.strobe[WR_BIT] = 1'b0;
               end else begin
                  s_d.ext.ad_oe = 1'b0;
                  if (s_q.kind == KIND_XREAD) begin
                     s_d.ext.strobe[RD_BIT] = 1'b0;
                  end else begin
                     s_d.ext.psen_n = 1'b0;
                  end
               end
               s_d.st = ST_DATA;
            end
         end
         ST_DATA: begin
            if (tick) begin
               // Sampled on the same edge that ends the strobe, while memory still drives
               if (s_q.kind != KIND_XWRITE) begin
                  s_d.ack.rdata = i_low_addr_data_port;
               end
               s_d.ext.psen_n   = 1'b1;
               s_d.ext.strobe   = STROBE_IDLE;
               s_d.ext.ad_oe    = 1'b0;
               s_d.ack.done     = 1'b1;
               s_d.ack.internal = 1'b0;
               s_d.busy         = 1'b0;
               s_d.st           = ST_IDLE;
            end
         end
         ST_ROM: begin
            // Internal fetch: no bus activity, one machine cycle
            if (tick) begin
               s_d.ack.rdata    = i_rom_data;
               s_d.ack.done     = 1'b1;
               s_d.ack.internal = 1'b1;
               s_d.busy         = 1'b0;
               s_d.st           = ST_IDLE;
            end
         end
         default: begin
            s_d.st = ST_IDLE;
         end
      endcase

      // ****************************************************************
      // Internal data memory and special registers
      // ****************************************************************
      if (s_q.imem_pend) begin
         // Special register answer arrives one cycle after the select
         s_d.imem_pend      = 1'b0;
         s_d.imem_ack.done  = 1'b1;
         s_d.imem_ack.rdata = i_sfr_rdata;
      end else if (i_imem.valid && !s_q.core_rst) begin
         ia = i_imem.addr;
         if (!i_imem.indirect && (ia >= SFR_BASE)) begin
            s_d.sfr.sel   = 1'b1;
            s_d.sfr.write = i_imem.write;
            s_d.sfr.addr  = ia;
            s_d.sfr.wdata = i_imem.wdata;
            s_d.imem_pend = 1'b1;
         end else if (ia <= IRAM_TOP) begin
            if (i_imem.write) begin
               s_d.ram[ia] = i_imem.wdata;
            end
            s_d.imem_ack.rdata = s_q.ram[ia];
            s_d.imem_ack.done  = 1'b1;
         end else begin
            // No RAM behind indirect C0H-FFH: writes dropped, reads fixed
            s_d.imem_ack.rdata = UNMAPPED_DATA;
            s_d.imem_ack.done  = 1'b1;
         end
      end

      // Core reset aborts any bus cycle and parks the pins
      if (s_q.core_rst) begin
         s_d.st         = ST_IDLE;
         s_d.busy       = 1'b0;
         s_d.imem_pend  = 1'b0;
         s_d.ext.ale    = 1'b0;
         s_d.ext.psen_n = 1'b1;
         s_d.ext.strobe = STROBE_IDLE;
         s_d.ext.ad_oe  = 1'b0;
      end

      // Block reset; the RAM is cleared too so contents are defined
      if (i_srst) begin
         s_d            = '0;
         s_d.st         = ST_IDLE;
         s_d.core_rst   = 1'b1;
         s_d.ext.psen_n = 1'b1;
         s_d.ext.strobe = STROBE_IDLE;
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge i_clk) begin
      s_q <= s_d;
   end

   // ****************************************************************
   // Outputs, all straight from state
   // ****************************************************************
   assign o_ack                   = s_q.ack;
   assign o_busy                  = s_q.busy;
   assign o_rom_addr              = s_q.rom_addr;
   assign o_imem_ack              = s_q.imem_ack;
   assign o_sfr                   = s_q.sfr;
   assign o_ale                   = s_q.ext.ale;
   assign o_psen_n                = s_q.ext.psen_n;
   assign o_strobe_port           = s_q.ext.strobe;
   assign o_low_addr_data_port    = s_q.ext.ad_out;
   assign o_low_addr_data_port_oe = s_q.ext.ad_oe;
   assign o_high_addr_port        = s_q.ext.hi;
   assign o_core_reset            = s_q.core_rst;
   assign o_fetch_internal        = s_q.strap;
endmodule : mmb_bus

// File: mmb_bus_props.sv
// Checker for the external bus pins and the internal memory decode.
// Assumes it is bound into mmb_bus and sees only that module's ports.

// ****************************************************************
// Checker
// ****************************************************************
module mmb_bus_props (
   input  wire logic                      i_clk,
   input  wire logic                      i_srst,
   input  wire logic                      i_reset_pin,
   input  wire mmb_pkg::mmb_imem_req_type i_imem,
   input  wire mmb_pkg::mmb_ack_type      o_ack,
   input  wire mmb_pkg::mmb_sfr_req_type  o_sfr,
   input  wire logic                      o_ale,
   input  wire logic                      o_psen_n,
   input  wire logic [7:0]                o_strobe_port,
   input  wire logic [7:0]                o_low_addr_data_port,
   input  wire logic                      o_low_addr_data_port_oe,
   input  wire logic [7:0]                o_high_addr_port,
   input  wire logic                      o_core_reset,
   input  wire logic                      o_fetch_internal
);
   import mmb_pkg::*;

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_srst);

   AST_ALE_DRIVES: assert property (o_ale |-> o_low_addr_data_port_oe)
      else $error("latch strobe high while low port released");
   AST_ALE_FALL_HOLD: assert property ($fell(o_ale) |-> o_low_addr_data_port_oe
      && $stable(o_low_addr_data_port) && $stable(o_high_addr_port))
      else $error("address moved at latch strobe fall");
   AST_PSEN_RELEASE: assert property (!o_psen_n |-> !o_low_addr_data_port_oe)
      else $error("low port driven during fetch strobe");
   AST_RD_RELEASE: assert property (!o_strobe_port[RD_BIT] |->
      !o_low_addr_data_port_oe && o_strobe_port[WR_BIT])
      else $error("low port driven during read strobe");
   AST_WR_DRIVES: assert property (!o_strobe_port[WR_BIT] |->
      o_low_addr_data_port_oe && o_psen_n)
      else $error("write strobe without driven data");
   AST_STROBE_SPARE: assert property (o_strobe_port[5:0] == 6'h3F)
      else $error("unused strobe bits not idle");
   AST_EXT_ABOVE_ROM: assert property (!o_psen_n && o_fetch_internal |->
      o_high_addr_port > 8'h0F)
      else $error("low 4K fetched outside while strap high");
   AST_SFR_DIRECT: assert property (o_sfr.sel |-> $past(i_imem.valid) &&
      !$past(i_imem.indirect) && $past(i_imem.addr) >= SFR_BASE)
      else $error("special register selected without direct upper access");
   AST_CORE_RESET_PIN: assert property ($rose(o_core_reset) |->
      $past(i_reset_pin, 1) && $past(i_reset_pin, 2))
      else $error("core reset without a held reset pin");

   // Main scenarios reached
   COV_FETCH: cover property ($fell(o_psen_n));
   COV_READ: cover property ($fell(o_strobe_port[RD_BIT]));
   COV_WRITE: cover property ($fell(o_strobe_port[WR_BIT]));
   COV_SFR: cover property (o_sfr.sel);
   COV_ROM: cover property (o_ack.done && o_ack.internal);
endmodule : mmb_bus_props

bind mmb_bus mmb_bus_props u_props (
   .i_clk                   (i_clk),
   .i_srst                  (i_srst),
   .i_reset_pin             (i_reset_pin),
   .i_imem                  (i_imem),
   .o_ack                   (o_ack),
   .o_sfr                   (o_sfr),
   .o_ale                   (o_ale),
   .o_psen_n                (o_psen_n),
   .o_strobe_port           (o_strobe_port),
   .o_low_addr_data_port    (o_low_addr_data_port),
   .o_low_addr_data_port_oe (o_low_addr_data_port_oe),
   .o_high_addr_port        (o_high_addr_port),
   .o_core_reset            (o_core_reset),
   .o_fetch_internal        (o_fetch_internal)
);

// File: mmb_ext_mem.sv
// External program and data memory behind the multiplexed bus.
// Assumes the bench resolves the low port from the bus output enable alone.

// ****************************************************************
// Memory model
// ****************************************************************
module mmb_ext_mem (
   input  wire logic        i_clk,
   input  wire logic        i_ale,
   input  wire logic        i_psen_n,
   input  wire logic [7:0]  i_strobe,
   input  wire logic [7:0]  i_ad,
   input  wire logic [7:0]  i_hi,
   output logic [7:0]       o_drive,
   output logic [15:0]      o_last_addr
);
   timeunit 1ns;
   timeprecision 1ps;
   bit   [7:0]  dmem [0:65535];
   logic [7:0]  held = 8'h00;
   logic [15:0] last = 16'h0000;

   always @(negedge i_ale) begin
      last = {i_hi, i_ad};
   end
   assign o_last_addr = last;

   // Drive only while the fetch or read strobe is low; otherwise a changed value
   always_comb begin
      if (!i_psen_n) begin
         o_drive = last[15:8] ^ ~last[7:0];
      end else if (!i_strobe[7]) begin
         o_drive = dmem[last];
      end else begin
         o_drive = ~held;
      end
   end

   // Write on low write strobe, remember last driven byte
   always @(posedge i_clk) begin
      if (!i_strobe[6]) begin
         dmem[last] <= i_ad;
      end
      if (!i_psen_n || !i_strobe[7]) begin
         held <= o_drive;
      end
   end
endmodule : mmb_ext_mem

// File: mmb_bus_tb.sv
// Self-checking bench for the memory map and external bus block.
// Assumes a short machine cycle of two clocks to keep the run brief.

// ****************************************************************
// Bench top
// ****************************************************************
module mmb_bus_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import mmb_pkg::*;
   localparam int DIV = 2;
   logic i_clk, i_srst, reset_pin, strap, busy, ale, psen_n, ad_oe, core_rst, fetch_int, f;
   mmb_req_type      req;
   mmb_ack_type      ack;
   mmb_imem_req_type imem;
   mmb_imem_ack_type imem_ack;
   mmb_sfr_req_type  sfr;
   logic [15:0] rom_addr, mdl_addr, a;
   logic [7:0]  rom_data, sfr_rdata, ad_out, ad_in, hi, strobe, mdl_drv, q, d, b;
   int miscompares, checks, seed, j;
   int ram [256];

   // ROM and special registers answer with address-derived bytes
   assign rom_data  = rom_addr[7:0] ^ rom_addr[15:8] ^ 8'h3C;
   assign sfr_rdata = sfr.addr ^ 8'h5A;
   assign ad_in     = ad_oe ? ad_out : mdl_drv;

   mmb_bus #(.MC_DIV_P(DIV), .RST_MC_P(2)) DUT (
      .i_clk(i_clk), .i_srst(i_srst), .i_reset_pin(reset_pin),
      .i_fetch_source_strap(strap), .i_req(req), .o_ack(ack), .o_busy(busy),
      .o_rom_addr(rom_addr), .i_rom_data(rom_data), .i_imem(imem), .o_imem_ack(imem_ack),
      .o_sfr(sfr), .i_sfr_rdata(sfr_rdata), .o_ale(ale), .o_psen_n(psen_n),
      .o_strobe_port(strobe), .o_low_addr_data_port(ad_out),
      .o_low_addr_data_port_oe(ad_oe), .i_low_addr_data_port(ad_in),
      .o_high_addr_port(hi), .o_core_reset(core_rst), .o_fetch_internal(fetch_int));

   mmb_ext_mem u_mem (.i_clk(i_clk), .i_ale(ale), .i_psen_n(psen_n), .i_strobe(strobe),
      .i_ad(ad_out), .i_hi(hi), .o_drive(mdl_drv), .o_last_addr(mdl_addr));

   // Free-running 100 MHz clock
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end

   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic conclude;
      if (miscompares == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : conclude

   task automatic hang;
      miscompares++;
      conclude();
   endtask : hang

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic flag(input logic got, input logic exp);
      chk({15'h0000, got}, {15'h0000, exp});
   endtask : flag

   // Hold the request until busy, then wait for done
   task automatic bus(input mmb_kind_type k, input logic x, input logic [15:0] ad,
                      input logic [7:0] wd);
      int n;
      @(negedge i_clk);
      req = '{valid: 1'b1, kind: k, idx_mode: x, addr: ad, wdata: wd};
      for (n = 0; busy !== 1'b1; n++) begin
         @(negedge i_clk);
         if (n > 50) hang();
      end
      req.valid = 1'b0;
      for (n = 0; ack.done !== 1'b1; n++) begin
         @(negedge i_clk);
         if (n > 50) hang();
      end
      q = ack.rdata;
      f = ack.internal;
   endtask : bus

   // One internal memory access; an idle cycle follows
   task automatic mem(input logic w, input logic ind, input logic [7:0] ad,
                      input logic [7:0] wd);
      int n;
      @(negedge i_clk);
      imem = '{valid: 1'b1, write: w, indirect: ind, addr: ad, wdata: wd};
      @(negedge i_clk);
      imem.valid = 1'b0;
      for (n = 0; imem_ack.done !== 1'b1; n++) begin
         @(negedge i_clk);
         if (n > 8) hang();
      end
      q = imem_ack.rdata;
      @(negedge i_clk);
   endtask : mem

   // Block reset, then release the pin and wait for the core
   task automatic boot(input logic s);
      int n;
      strap = s;
      reset_pin = 1'b1;
      i_srst = 1'b1;
      foreach (ram[k]) ram[k] = 0;
      repeat (20) @(negedge i_clk);
      i_srst = 1'b0;
      repeat (3 * DIV) @(negedge i_clk);
      reset_pin = 1'b0;
      for (n = 0; core_rst !== 1'b0; n++) begin
         @(negedge i_clk);
         if (n > 20) hang();
      end
      flag(fetch_int, s);
   endtask : boot

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      seed = 52927;
      miscompares = 0;
      checks = 0;
      req = '0;
      imem = '0;
      boot(1'b1);
      // Strap moves after release; the latched choice must hold
      strap = 1'b0;
      // ROM edges, first external page, top of space, random spots
      for (j = 0; j < 6; j++) begin
         a = (j == 0) ? 16'h0000 : (j == 1) ? 16'h0FFF : (j == 2) ? 16'h1000 :
             (j == 3) ? 16'hFFFF : 16'($random(seed));
         bus(KIND_FETCH, 1'b0, a, 8'h00);
         flag(f, a <= 16'h0FFF);
         b = (a <= 16'h0FFF) ? a[7:0] ^ a[15:8] ^ 8'h3C : a[15:8] ^ ~a[7:0];
         chk({8'h00, q}, {8'h00, b});
         if (a > 16'h0FFF) chk(mdl_addr, a);
      end
      // Every source plus one past the end
      for (j = 0; j < 6; j++) begin
         bus(KIND_VECTOR, 1'b0, {13'h0000, j[2:0]}, 8'h00);
         chk(rom_addr, (j < 5) ? 16'h0003 + 16'h0008 * j[15:0] : 16'h0023);
      end
      // External data, pointer and register-indexed alternately
      for (j = 0; j < 6; j++) begin
         a = 16'($random(seed));
         d = 8'($random(seed));
         bus(KIND_XWRITE, j[0], a, d);
         chk(mdl_addr, j[0] ? {8'h00, a[7:0]} : a);
         bus(KIND_XREAD, j[0], a, 8'h00);
         chk({8'h00, q}, {8'h00, d});
      end
      // Internal RAM, upper half only indirect
      for (j = 0; j < 10; j++) begin
         b = (j == 0) ? 8'hBF : (j == 1) ? 8'h00 : 8'($random(seed)) % 8'hC0;
         d = 8'($random(seed));
         mem(1'b1, j[0] | (b >= 8'h80), b, d);
         ram[b] = d;
         mem(1'b0, ~j[0] | (b >= 8'h80), b, 8'h00);
         chk({8'h00, q}, {8'h00, ram[b][7:0]});
      end
      mem(1'b1, 1'b1, 8'h90, 8'h33);
      mem(1'b0, 1'b0, 8'h90, 8'h00);
      chk({8'h00, q}, {8'h00, 8'h90 ^ 8'h5A});
      mem(1'b0, 1'b1, 8'h90, 8'h00);
      chk({8'h00, q}, 16'h0033);
      // Direct write to the upper region reaches a special register, not RAM
      mem(1'b1, 1'b0, 8'hA5, 8'h6C);
      chk({sfr.addr, sfr.wdata}, 16'hA56C);
      flag(sfr.write, 1'b1);
      mem(1'b0, 1'b1, 8'hA5, 8'h00);
      chk({8'h00, q}, {8'h00, ram[8'hA5][7:0]});
      mem(1'b1, 1'b1, 8'hC5, 8'h77);
      mem(1'b0, 1'b1, 8'hC5, 8'h00);
      chk({8'h00, q}, 16'h0000);
      // A one-cycle pin pulse is filtered, a long one resets the core
      reset_pin = 1'b1;
      repeat (DIV) @(negedge i_clk);
      reset_pin = 1'b0;
      repeat (2 * DIV) @(negedge i_clk);
      flag(core_rst, 1'b0);
      reset_pin = 1'b1;
      repeat (3 * DIV) @(negedge i_clk);
      flag(core_rst, 1'b1);
      flag(fetch_int, 1'b0);
      // Strap low sends even address zero outside
      boot(1'b0);
      bus(KIND_FETCH, 1'b0, 16'h0000, 8'h00);
      flag(f, 1'b0);
      chk({8'h00, q}, 16'h00FF);
      conclude();
   end
endmodule : mmb_bus_tb
